// >>> design/nibcpu_core.sv
// Nibble core executor with register bus, flags and interrupt
//
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module nibcpu_core (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // Program ROM, combinational outside
  output logic [13:0]      rom_addr_o,
  input  wire logic [9:0]  rom_data_i,
  // Event sources
  input  wire logic        ext_int_i,
  input  wire logic        timer1_uf_i,
  input  wire logic        timer2_uf_i,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_result_i,
  // Converter and port
  output logic             conv_start_o,
  output logic             conv_cmp_mode_o,
  output logic [1:0]       p2_o,
  output logic             irq_o,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    nibcpu_pkg::nibcpu_fsm_e fsm;
    logic [13:0]             pc;
    logic [13:0]             rom_addr;
    logic [7:0][13:0]        sk;
    logic [2:0]              sp;
    logic [3:0]              acc;
    logic [3:0]              b;
    logic [7:0]              e;
    logic [2:0]              d;
    logic [3:0]              x;
    logic [3:0]              y;
    logic [1:0]              z;
    logic                    skip;
    logic [5:0]              ctrl;
    logic [3:0]              flag;
    logic [3:0]              istat;
    logic [3:0]              imask;
    logic                    irq;
    logic [1:0]              p2;
    logic                    conv_start;
    logic                    ack;
    logic [31:0]             rdata;
    logic [1:0]              sync;
    logic                    ext_prev;
  } nibcpu_core_s;

  nibcpu_core_s           q_ff;
  nibcpu_core_s           nxt_q;
  nibcpu_pkg::nibcpu_dec_s dec;
  logic [3:0]             ram [0:1023];
  logic [9:0]             dp;
  logic                   ram_we;
  logic [3:0]             mem_rd;
  logic [3:0]             events;
  logic [3:0]             flag_clr;
  logic                   ext_edge;
  logic                   bus_req;
  logic                   bus_done;
  logic [13:0]            npc;
  logic [2:0]             sp_up;
  logic [4:0]             sum;

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  nibcpu_decode u_decode (
    .instr_i (rom_data_i),
    .dec_o   (dec)
  );

  // ----------------------------------------------------------------
  // Data memory
  // ----------------------------------------------------------------
  assign dp     = {q_ff.z, q_ff.x, q_ff.y};
  assign mem_rd = ram[dp];

  // Array kept outside the reset struct: no reset needed, maps to RAM
  always_ff @(posedge ref_clk_i) begin
    if (ram_we) begin
      ram[dp] <= q_ff.acc;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [4:0] a,
                                   input logic [4:0] off);
    reg_hit = (a == off);
  endfunction

  assign ext_edge = q_ff.sync[1] & ~q_ff.ext_prev;
  assign events   = {conv_done_i, timer2_uf_i, timer1_uf_i, ext_edge};
  assign sp_up    = q_ff.sp + 3'h1;
  assign bus_req  = avs_read_i | avs_write_i;
  assign bus_done = bus_req & q_ff.ack;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q      = q_ff;
    ram_we     = 1'b0;
    flag_clr   = 4'h0;
    npc        = q_ff.pc + 14'h0001;
    sum        = {1'b0, q_ff.acc} + {1'b0, dec.imm[3:0]};
    nxt_q.sync = {q_ff.sync[0], ext_int_i};
    nxt_q.ext_prev   = q_ff.sync[1];
    nxt_q.conv_start = 1'b0;

    case (q_ff.fsm)
      nibcpu_pkg::ST_RUN: begin
        if (q_ff.ctrl[nibcpu_pkg::CTRL_RUN]) begin
          nxt_q.skip = 1'b0;
          // A skipped word is still fetched; only its effect is dropped
          if (!q_ff.skip) begin
            case (dec.op)
              nibcpu_pkg::OP_LOAD_EXT_FROM_PAIR: begin
                nxt_q.e = {q_ff.b, q_ff.acc};
              end
              nibcpu_pkg::OP_TABE: begin
                nxt_q.b   = q_ff.e[7:4];
                nxt_q.acc = q_ff.e[3:0];
              end
              nibcpu_pkg::OP_READ_STACK_POINTER: begin
                nxt_q.acc = {1'b0, q_ff.sp};
              end
              nibcpu_pkg::OP_RT,
              nibcpu_pkg::OP_RTS: begin
                npc        = q_ff.sk[q_ff.sp];
                nxt_q.sp   = q_ff.sp - 3'h1;
                nxt_q.skip = (dec.op == nibcpu_pkg::OP_RTS);
                nxt_q.fsm  = nibcpu_pkg::ST_RET;
              end
              nibcpu_pkg::OP_ROM_TABLE_LOOKUP: begin
                // The table word arrives next cycle on the redirected fetch
                nxt_q.sp        = sp_up;
                nxt_q.sk[sp_up] = npc;
                npc = {2'b00, dec.imm[4:0], q_ff.d, q_ff.acc};
                nxt_q.fsm = nibcpu_pkg::ST_LOOK;
              end
              nibcpu_pkg::OP_BM: begin
                // Eight levels only: a ninth call wraps and overwrites the oldest
                nxt_q.sp        = sp_up;
                nxt_q.sk[sp_up] = npc;
                npc = {7'h02, dec.imm[6:0]};
              end
              nibcpu_pkg::OP_B: begin
                npc = {q_ff.pc[13:7], dec.imm[6:0]};
              end
              nibcpu_pkg::OP_SEA: begin
                nxt_q.skip = (q_ff.acc == dec.imm[3:0]);
              end
              nibcpu_pkg::OP_ADDI: begin
                nxt_q.acc  = sum[3:0];
                nxt_q.skip = ~sum[4];
              end
              nibcpu_pkg::OP_LA: begin
                nxt_q.acc = dec.imm[3:0];
              end
              nibcpu_pkg::OP_LXY: begin
                nxt_q.x = dec.imm[7:4];
                nxt_q.y = dec.imm[3:0];
              end
              nibcpu_pkg::OP_LZ: begin
                nxt_q.z = dec.imm[1:0];
              end
              nibcpu_pkg::OP_TDA: begin
                nxt_q.d = q_ff.acc[2:0];
              end
              nibcpu_pkg::OP_TAM: begin
                nxt_q.acc = mem_rd;
              end
              nibcpu_pkg::OP_TMA: begin
                ram_we = 1'b1;
              end
              nibcpu_pkg::OP_TAB: begin
                nxt_q.acc = q_ff.b;
              end
              nibcpu_pkg::OP_TBA: begin
                nxt_q.b = q_ff.acc;
              end
              nibcpu_pkg::OP_SKEXT: begin
                if (!q_ff.ctrl[nibcpu_pkg::CTRL_V10]) begin
                  nxt_q.skip = q_ff.flag[nibcpu_pkg::EV_EXT];
                  flag_clr[nibcpu_pkg::EV_EXT] = 1'b1;
                end
              end
              nibcpu_pkg::OP_SKT1: begin
                if (!q_ff.ctrl[nibcpu_pkg::CTRL_V12]) begin
                  nxt_q.skip = q_ff.flag[nibcpu_pkg::EV_T1];
                  flag_clr[nibcpu_pkg::EV_T1] = 1'b1;
                end
              end
              nibcpu_pkg::OP_SKT2: begin
                if (!q_ff.ctrl[nibcpu_pkg::CTRL_V13]) begin
                  nxt_q.skip = q_ff.flag[nibcpu_pkg::EV_T2];
                  flag_clr[nibcpu_pkg::EV_T2] = 1'b1;
                end
              end
              nibcpu_pkg::OP_SKCNV: begin
                if (!q_ff.ctrl[nibcpu_pkg::CTRL_V22]) begin
                  nxt_q.skip = q_ff.flag[nibcpu_pkg::EV_CNV];
                  flag_clr[nibcpu_pkg::EV_CNV] = 1'b1;
                end
              end
              nibcpu_pkg::OP_CONV: begin
                // Mode output selects conversion or comparator
                nxt_q.conv_start = 1'b1;
                flag_clr[nibcpu_pkg::EV_CNV] = 1'b1;
              end
              nibcpu_pkg::OP_RDRES: begin
                if (q_ff.ctrl[nibcpu_pkg::CTRL_Q13]) begin
                  nxt_q.b   = conv_result_i[7:4];
                  nxt_q.acc = conv_result_i[3:0];
                end else begin
                  nxt_q.b   = conv_result_i[9:6];
                  nxt_q.acc = conv_result_i[5:2];
                end
              end
              nibcpu_pkg::OP_RDLOW: begin
                nxt_q.acc = {conv_result_i[1:0], 2'b00};
              end
              nibcpu_pkg::OP_WRP2: begin
                nxt_q.p2 = q_ff.acc[1:0];
              end
              default: begin
              end
            endcase
          end
          nxt_q.pc       = npc;
          nxt_q.rom_addr = npc;
        end
      end
      nibcpu_pkg::ST_LOOK: begin
        // ROM word of the table address is on the fetch bus now
        nxt_q.b        = rom_data_i[7:4];
        nxt_q.acc      = rom_data_i[3:0];
        nxt_q.pc       = q_ff.sk[q_ff.sp];
        nxt_q.rom_addr = q_ff.sk[q_ff.sp];
        nxt_q.sp       = q_ff.sp - 3'h1;
        nxt_q.fsm      = nibcpu_pkg::ST_RUN;
      end
      nibcpu_pkg::ST_RET: begin
        // Return target is already being fetched; this cycle only waits
        nxt_q.fsm = nibcpu_pkg::ST_RUN;
      end
      default: begin
        nxt_q.fsm = nibcpu_pkg::ST_RUN;
      end
    endcase

    // ----------------------------------------------------------------
    // Request flags
    // ----------------------------------------------------------------

    // Set wins over a same-cycle clear
    nxt_q.flag = (q_ff.flag & ~flag_clr) | events;

    // ----------------------------------------------------------------
    // Register bus: one wait cycle, data captured in the first
    // ----------------------------------------------------------------
    nxt_q.ack = bus_req & ~q_ff.ack;
    if (avs_read_i && !q_ff.ack) begin
      nxt_q.rdata = 32'h0000_0000;
      if (reg_hit(avs_address_i, nibcpu_pkg::REG_CTRL)) begin
        nxt_q.rdata[5:0] = q_ff.ctrl;
      end
      if (reg_hit(avs_address_i, nibcpu_pkg::REG_CORE)) begin
        nxt_q.rdata[20:0] = {q_ff.flag, q_ff.sp, q_ff.pc};
      end
      if (reg_hit(avs_address_i, nibcpu_pkg::REG_WORK)) begin
        nxt_q.rdata[30:0] = {q_ff.p2, q_ff.z, q_ff.x, q_ff.y, q_ff.d,
                             q_ff.e, q_ff.b, q_ff.acc};
      end
      if (reg_hit(avs_address_i, nibcpu_pkg::REG_ISTAT)) begin
        nxt_q.rdata[3:0] = q_ff.istat;
      end
      if (reg_hit(avs_address_i, nibcpu_pkg::REG_IMASK)) begin
        nxt_q.rdata[3:0] = q_ff.imask;
      end
    end

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------

    // Only bits already reported are cleared, so a new event survives
    nxt_q.istat = q_ff.istat | events;
    if (bus_done && avs_read_i &&
        reg_hit(avs_address_i, nibcpu_pkg::REG_ISTAT)) begin
      nxt_q.istat = (q_ff.istat & ~q_ff.rdata[3:0]) | events;
    end

    if (bus_done && avs_write_i && avs_byteenable_i[0]) begin
      if (reg_hit(avs_address_i, nibcpu_pkg::REG_CTRL)) begin
        nxt_q.ctrl = avs_writedata_i[5:0];
      end
      if (reg_hit(avs_address_i, nibcpu_pkg::REG_IMASK)) begin
        nxt_q.imask = avs_writedata_i[3:0];
      end
    end

    nxt_q.irq = |(nxt_q.istat & nxt_q.imask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_ff      <= '0;
      q_ff.fsm  <= nibcpu_pkg::ST_RUN;
      q_ff.ctrl <= nibcpu_pkg::CTRL_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rom_addr_o        = q_ff.rom_addr;
  assign conv_start_o      = q_ff.conv_start;
  assign conv_cmp_mode_o   = q_ff.ctrl[nibcpu_pkg::CTRL_Q13];
  assign p2_o              = q_ff.p2;
  assign irq_o             = q_ff.irq;
  assign avs_readdata_o    = q_ff.rdata;
  assign avs_waitrequest_o = bus_req & ~q_ff.ack;

endmodule

// >>> design/nibcpu_pkg.sv
// Constants, types and encodings shared by the nibble core files
package nibcpu_pkg;

  // ----------------------------------------------------------------
  // Core sizes
  // ----------------------------------------------------------------
  localparam int PC_W   = 14;
  localparam int PAGE_W = 7;
  localparam int DP_W   = 10;
  localparam int SK_N   = 8;
  localparam int SP_W   = 3;
  localparam int INS_W  = 10;

  // ----------------------------------------------------------------
  // Fixed opcodes
  // ----------------------------------------------------------------
  localparam logic [9:0] OPC_NOP   = 10'h000;
  localparam logic [9:0] OPC_LOAD_EXT_FROM_PAIR  = 10'h200;
  localparam logic [9:0] OPC_TABE  = 10'h201;
  localparam logic [9:0] OPC_READ_STACK_POINTER  = 10'h202;
  localparam logic [9:0] OPC_RT    = 10'h203;
  localparam logic [9:0] OPC_RTS   = 10'h204;
  localparam logic [9:0] OPC_SKEXT = 10'h205;
  localparam logic [9:0] OPC_SKT1  = 10'h206;
  localparam logic [9:0] OPC_SKT2  = 10'h207;
  localparam logic [9:0] OPC_SKCNV = 10'h208;
  localparam logic [9:0] OPC_RDRES = 10'h209;
  localparam logic [9:0] OPC_RDLOW = 10'h20a;
  localparam logic [9:0] OPC_WRP2  = 10'h20b;
  localparam logic [9:0] OPC_TAM   = 10'h20c;
  localparam logic [9:0] OPC_TMA   = 10'h20d;
  localparam logic [9:0] OPC_TAB   = 10'h20e;
  localparam logic [9:0] OPC_TBA   = 10'h20f;
  localparam logic [9:0] OPC_TDA   = 10'h210;
  localparam logic [9:0] OPC_CONV  = 10'h29f;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL  = 5'h00;
  localparam logic [4:0] REG_CORE  = 5'h04;
  localparam logic [4:0] REG_WORK  = 5'h08;
  localparam logic [4:0] REG_ISTAT = 5'h0c;
  localparam logic [4:0] REG_IMASK = 5'h10;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_V10 = 1;
  localparam int CTRL_V12 = 2;
  localparam int CTRL_V13 = 3;
  localparam int CTRL_V22 = 4;
  localparam int CTRL_Q13 = 5;
  localparam int CTRL_W   = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam int EV_EXT = 0;
  localparam int EV_T1  = 1;
  localparam int EV_T2  = 2;
  localparam int EV_CNV = 3;
  localparam int EV_W   = 4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_LOAD_EXT_FROM_PAIR, OP_TABE, OP_READ_STACK_POINTER, OP_RT, OP_RTS, OP_SKEXT,
    OP_SKT1, OP_SKT2, OP_SKCNV, OP_RDRES, OP_RDLOW, OP_WRP2,
    OP_TAM, OP_TMA, OP_TAB, OP_TBA, OP_TDA, OP_CONV, OP_ADDI,
    OP_LA, OP_SEA, OP_LZ, OP_ROM_TABLE_LOOKUP, OP_B, OP_BM, OP_LXY
  } nibcpu_op_e;

  typedef struct packed {
    nibcpu_op_e op;
    logic [7:0] imm;
  } nibcpu_dec_s;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_LOOK = 3'b010,
    ST_RET  = 3'b100
  } nibcpu_fsm_e;

endpackage

// >>> design/nibcpu_decode.sv
// Instruction word to operation decoder
`timescale 1ns/1ps
module nibcpu_decode (
  input  wire logic [9:0]         instr_i,
  output nibcpu_pkg::nibcpu_dec_s dec_o
);

  always_comb begin
    dec_o.imm = instr_i[7:0];
    casez (instr_i)
      nibcpu_pkg::OPC_LOAD_EXT_FROM_PAIR:  dec_o.op = nibcpu_pkg::OP_LOAD_EXT_FROM_PAIR;
      nibcpu_pkg::OPC_TABE:  dec_o.op = nibcpu_pkg::OP_TABE;
      nibcpu_pkg::OPC_READ_STACK_POINTER:  dec_o.op = nibcpu_pkg::OP_READ_STACK_POINTER;
      nibcpu_pkg::OPC_RT:    dec_o.op = nibcpu_pkg::OP_RT;
      nibcpu_pkg::OPC_RTS:   dec_o.op = nibcpu_pkg::OP_RTS;
      nibcpu_pkg::OPC_SKEXT: dec_o.op = nibcpu_pkg::OP_SKEXT;
      nibcpu_pkg::OPC_SKT1:  dec_o.op = nibcpu_pkg::OP_SKT1;
      nibcpu_pkg::OPC_SKT2:  dec_o.op = nibcpu_pkg::OP_SKT2;
      nibcpu_pkg::OPC_SKCNV: dec_o.op = nibcpu_pkg::OP_SKCNV;
      nibcpu_pkg::OPC_RDRES: dec_o.op = nibcpu_pkg::OP_RDRES;
      nibcpu_pkg::OPC_RDLOW: dec_o.op = nibcpu_pkg::OP_RDLOW;
      nibcpu_pkg::OPC_WRP2:  dec_o.op = nibcpu_pkg::OP_WRP2;
      nibcpu_pkg::OPC_TAM:   dec_o.op = nibcpu_pkg::OP_TAM;
      nibcpu_pkg::OPC_TMA:   dec_o.op = nibcpu_pkg::OP_TMA;
      nibcpu_pkg::OPC_TAB:   dec_o.op = nibcpu_pkg::OP_TAB;
      nibcpu_pkg::OPC_TBA:   dec_o.op = nibcpu_pkg::OP_TBA;
      nibcpu_pkg::OPC_TDA:   dec_o.op = nibcpu_pkg::OP_TDA;
      nibcpu_pkg::OPC_CONV:  dec_o.op = nibcpu_pkg::OP_CONV;
      10'b00_0100_10??:      dec_o.op = nibcpu_pkg::OP_LZ;
      10'b00_0101_????:      dec_o.op = nibcpu_pkg::OP_SEA;
      10'b00_0110_????:      dec_o.op = nibcpu_pkg::OP_ADDI;
      10'b00_0111_????:      dec_o.op = nibcpu_pkg::OP_LA;
      10'b00_100?_????:      dec_o.op = nibcpu_pkg::OP_ROM_TABLE_LOOKUP;
      10'b01_0???_????:      dec_o.op = nibcpu_pkg::OP_BM;
      10'b01_1???_????:      dec_o.op = nibcpu_pkg::OP_B;
      10'b11_????_????:      dec_o.op = nibcpu_pkg::OP_LXY;
      default:               dec_o.op = nibcpu_pkg::OP_NOP;
    endcase
  end

endmodule

// >>> sim/nibcpu_core_props.sv
// Port-level concurrent checks of the nibble core
`timescale 1ns/1ps
module nibcpu_props (
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  input wire logic [13:0] rom_addr_o,
  input wire logic [9:0]  rom_data_i,
  input wire logic        conv_start_o,
  input wire logic        conv_cmp_mode_o,
  input wire logic [1:0]  p2_o,
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o
);
  wire logic [4:0] tab_page = rom_data_i[4:0];
  wire logic       rd_done = avs_read_i && !avs_waitrequest_o;
  wire logic       ctl_wr = avs_write_i && !avs_waitrequest_o
                            && avs_address_i == nibcpu_pkg::REG_CTRL;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ------------------------------------------------------------
  // Table lookup steps
  // ------------------------------------------------------------
  // A lookup leaves the straight line; a skipped one does not
  sequence tab_fetch;
    rom_data_i[9:5] == 5'h04 ##1 rom_addr_o != $past(rom_addr_o) + 14'h1;
  endsequence
  sequence tab_return;
    ##1 rom_addr_o == $past(rom_addr_o, 2) + 14'h1;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_wait_one: assert property ($rose(avs_read_i || avs_write_i)
    |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("waitrequest not one cycle");
  chk_unmapped_zero: assert property (rd_done && avs_address_i == 5'h14
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  chk_ctrl_upper: assert property (rd_done && avs_address_i == nibcpu_pkg::REG_CTRL
    |-> avs_readdata_o[31:6] == 26'h0) else $error("control upper bits set");
  chk_start_cause: assert property (
    conv_start_o |-> $past(rom_data_i) == nibcpu_pkg::OPC_CONV) else $error("stray start");
  chk_mode_cause: assert property (
    $changed(conv_cmp_mode_o) |-> $past(ctl_wr)) else $error("mode moved without write");
  chk_port_cause: assert property (
    $changed(p2_o) |-> $past(rom_data_i) == nibcpu_pkg::OPC_WRP2) else $error("stray port write");
  chk_skip_step: assert property (rom_data_i[9:4] == 6'h05 ##1 $changed(rom_addr_o)
    |-> rom_addr_o == $past(rom_addr_o) + 14'h1) else $error("compare moved pc by two");
  chk_skip_return: assert property (rom_data_i == nibcpu_pkg::OPC_RT
    ##1 rom_addr_o == $past(rom_addr_o) + 14'h1 |=> $changed(rom_addr_o))
    else $error("skipped return held two cycles");
  chk_table_page: assert property (tab_fetch
    |-> rom_addr_o[13:7] == {2'b00, $past(tab_page)} and tab_return)
    else $error("lookup page or return wrong");
endmodule

bind nibcpu_core nibcpu_props nibcpu_props_i (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .rom_addr_o(rom_addr_o),
  .rom_data_i(rom_data_i), .conv_start_o(conv_start_o), .conv_cmp_mode_o(conv_cmp_mode_o),
  .p2_o(p2_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o)
);

// >>> sim/test_nibcpu_core.sv
// Self-checking bench for the nibble core executor
`timescale 1ns/1ps
module test_nibcpu_core;
  logic        ref_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [13:0] rom_addr_o;
  logic [9:0]  rom_data_i;
  logic [3:0]  ev_i = 4'h0;
  logic [9:0]  conv_result_i = 10'h2d6;
  logic        conv_start_o;
  logic        conv_cmp_mode_o;
  logic        irq_o;
  logic        avs_waitrequest_o;
  logic [1:0]  p2_o;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic [31:0] rd;
  logic [31:0] work;
  logic [31:0] core;
  logic [9:0]  rom [16384];
  int          fail_count = 0;
  int          tests_run = 0;
  int          starts = 0;

  always #4 ref_clk_i = ~ref_clk_i;
  assign rom_data_i = rom[rom_addr_o];
  always @(posedge ref_clk_i) if (conv_start_o === 1'b1) starts++;

  nibcpu_core nibcpu_core_i (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .rom_addr_o(rom_addr_o),
    .rom_data_i(rom_data_i), .ext_int_i(ev_i[0]), .timer1_uf_i(ev_i[1]),
    .timer2_uf_i(ev_i[2]), .conv_done_i(ev_i[3]), .conv_result_i(conv_result_i),
    .conv_start_o(conv_start_o), .conv_cmp_mode_o(conv_cmp_mode_o), .p2_o(p2_o),
    .irq_o(irq_o), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // Holds the request until a rising edge sees waitrequest low; only the watchdog ends a hang
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= ~w;
    @(posedge ref_clk_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge ref_clk_i);
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task irq(input logic e);
    @(negedge ref_clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
    @(posedge ref_clk_i);
  endtask

  task rst;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
  endtask

  // Every program ends in a branch to itself so the core parks there
  task load(input int b, input logic [9:0] p [$]);
    if (b == 0) begin
      foreach (rom[i]) rom[i] = 10'h000;
    end
    foreach (p[i]) rom[b + i] = p[i];
    rom[b + p.size()] = 10'h180 | 10'((b + p.size()) % 128);
  endtask

  task go(input logic [5:0] c, input logic [3:0] ev, input int n);
    rst();
    ev_i <= ev;
    @(posedge ref_clk_i);
    ev_i <= 4'h0;
    repeat (3) @(posedge ref_clk_i);
    bus(1'b1, nibcpu_pkg::REG_CTRL, {26'h0, c | 6'h01});
    repeat (n) @(posedge ref_clk_i);
    bus(1'b1, nibcpu_pkg::REG_CTRL, {26'h0, c});
    bus(1'b0, nibcpu_pkg::REG_WORK, 32'h0);
    work = rd;
    bus(1'b0, nibcpu_pkg::REG_CORE, 32'h0);
    core = rd;
  endtask

  task results;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_bus;
    rst();
    bus(1'b0, nibcpu_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, nibcpu_pkg::REG_CTRL, 32'h3e);
    avs_byteenable_i <= 4'he;
    bus(1'b1, nibcpu_pkg::REG_CTRL, 32'h0);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, nibcpu_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h3e);
    bus(1'b0, 5'h14, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, nibcpu_pkg::REG_IMASK, 32'h1);
    ev_i <= 4'h2;
    @(posedge ref_clk_i);
    ev_i <= 4'h0;
    irq(1'b0);
    bus(1'b1, nibcpu_pkg::REG_IMASK, 32'h2);
    irq(1'b1);
    bus(1'b0, nibcpu_pkg::REG_ISTAT, 32'h0);
    chk(rd, 32'h2);
    irq(1'b0);
    bus(1'b0, nibcpu_pkg::REG_ISTAT, 32'h0);
    chk(rd, 32'h0);
    $display("test bus and interrupt done");
  endtask

  task t_moves;
    // Two RAM cells differing only in Z prove the pointer's top bits
    load(0, '{10'h3a5, 10'h04a, 10'h07c, 10'h20f, 10'h07e, 10'h20b,
              10'h073, 10'h200, 10'h070, 10'h20f, 10'h201, 10'h20d,
              10'h049, 10'h070, 10'h20d, 10'h04a, 10'h20c, 10'h063, 10'h07f});
    go(6'h00, 4'h0, 30);
    chk(work, {1'b0, 2'b10, 2'h2, 4'ha, 4'h5, 3'h0, 8'hc3, 4'hc, 4'h6});
    chk({30'h0, p2_o}, 32'h2);
    $display("test transfers done");
  endtask

  // Call, stack read, skipped return, miss and hit compares, table lookup
  task t_call;
    load(0, '{10'h110});
    load(14'h110, '{10'h202, 10'h20f, 10'h200, 10'h07f, 10'h05f, 10'h203,
                    10'h073, 10'h052, 10'h210, 10'h076, 10'h081, 10'h203});
    rom[14'h0b6] = 10'h3a7;
    go(6'h00, 4'h0, 30);
    chk(work, 32'h0003_11a7);
    chk(core, 32'h0000_0001);
    $display("test call and lookup done");
  endtask

  task t_flags;
    for (int k = 0; k < 4; k++) begin
      for (int m = 0; m < 3; m++) begin
        load(0, '{10'h070, 10'h205 + 10'(k), 10'h079});
        go((m == 2) ? 6'h01 << (k + 1) : 6'h00, (m > 0) ? 4'h1 << k : 4'h0, 10);
        chk({28'h0, work[3:0]}, (m == 1) ? 32'h0 : 32'h9);
        chk({31'h0, core[17 + k]}, {31'h0, m == 2});
      end
    end
    $display("test request skips done");
  endtask

  task t_conv;
    for (int q = 0; q < 2; q++) begin
      load(0, '{10'h29f, 10'h209, 10'h200, 10'h20a});
      starts = 0;
      go((q == 1) ? 6'h20 : 6'h00, 4'h0, 10);
      chk(starts, 32'h1);
      chk({31'h0, conv_cmp_mode_o}, q);
      chk({16'h0, work[15:0]}, (q == 1) ? 32'hd6d8 : 32'hb5b8);
    end
    $display("test converter done");
  endtask

  initial begin
    rst();
    t_bus();
    t_moves();
    t_call();
    t_flags();
    t_conv();
    results();
  end

  // A run takes about five hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    results();
  end
endmodule
